// *** rtl/fmp_map.svh ***
// Purpose: Offsets, field positions, reset values and timing of the fault report framer
// Assumes: Byte addressed register port, one 32-bit word per register
// Notes: Definitions only
`ifndef FMP_MAP_SVH
`define FMP_MAP_SVH

`define FMP_CLK_HZ 25000000
`define FMP_PERIOD_MS 1000

`define FMP_OFF_CTRL 8'h00
`define FMP_OFF_DATE_HI 8'h04
`define FMP_OFF_DATE_LO 8'h08
`define FMP_OFF_USEC 8'h0c
`define FMP_OFF_FAULT 8'h10
`define FMP_OFF_STATUS 8'h14

`define FMP_CTRL_EN 0
`define FMP_CTRL_VER 15:8
`define FMP_CTRL_STATE 18:16
`define FMP_FAULT_CODE 15:0
`define FMP_FAULT_POS 19:16
`define FMP_FAULT_CNT 23:20

`define FMP_RST_CTRL 32'h0000_0001
`define FMP_RST_DATE_HI 32'h4601_0100
`define FMP_RST_DATE_LO 32'h0000_0000
`define FMP_RST_USEC 32'h0000_0000
`define FMP_RST_FAULT 32'h0000_0000

`define FMP_USEC_MAX 32'd999999
`define FMP_YEAR_MIN 8'd70
`define FMP_SYNC0 8'hee
`define FMP_SYNC1 8'hdd
`define FMP_CRC_POLY 32'h04c1_1db7
`define FMP_CRC_INIT 32'hffff_ffff

`define FMP_IDX_SYNC0 6'd0
`define FMP_IDX_SYNC1 6'd1
`define FMP_IDX_VER 6'd2
`define FMP_IDX_DATE 6'd3
`define FMP_IDX_USEC 6'd9
`define FMP_IDX_STATE 6'd13
`define FMP_IDX_QUEUE 6'd14
`define FMP_IDX_CODE 6'd15
`define FMP_IDX_RSVD 6'd17
`define FMP_IDX_CRC 6'd37
`define FMP_IDX_LAST 6'd40

`endif

// *** rtl/fmp_pkg.sv ***
// Purpose: Types shared by the fault report framer
// Assumes: Constants live in fmp_map.svh
// Notes: Snapshot frozen for the length of one packet
package fmp_pkg;
  typedef logic [7:0] fmp_byte_t;

  typedef enum logic [1:0] {
    FMP_IDLE = 2'b00,
    FMP_SEND = 2'b01,
    FMP_DRAIN = 2'b10
  } fmp_state_e;

  typedef struct packed {
    logic [7:0] version;
    logic [5:0][7:0] date;
    logic [31:0] usec;
    logic [2:0] op_state;
    logic [3:0] count;
    logic [3:0] position;
    logic [15:0] code;
  } fmp_snap_s;
endpackage : fmp_pkg

// *** rtl/fmp_crc_if.sv ***
// Purpose: Byte feed between the framer and its checksum engine
// Assumes: Single clock
// Notes: Value is valid the cycle after the last fed byte
`timescale 1ns/1ps
interface fmp_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [31:0] value;

  modport user (output init, output en, output data, input value);
  modport engine (input init, input en, input data, output value);
endinterface : fmp_crc_if

// *** rtl/fmp_crc.sv ***
// Purpose: Bytewise CRC-32/MPEG-2 engine
// Assumes: Init and en never both high
// Notes: MSB first, no reflection, no final XOR
`timescale 1ns/1ps
`include "fmp_map.svh"
module fmp_crc (
  input wire logic clk,
  input wire logic rst,
  fmp_crc_if.engine crc
);
  import fmp_pkg::*;

  logic [31:0] crc_reg;
  logic [31:0] crc_next;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0} ^ (fb ? `FMP_CRC_POLY : 32'h0000_0000);
    end
    return r;
  endfunction : crc_byte

  always_comb begin
    crc_next = crc_reg;
    if (crc.init) begin
      crc_next = `FMP_CRC_INIT; // RL12
    end else if (crc.en) begin
      crc_next = crc_byte(crc_reg, crc.data); // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_reg <= `FMP_CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc.value = crc_reg;
endmodule : fmp_crc

// *** rtl/fmp_framer.sv ***
// Purpose: Periodic fault report packet builder with register port
// Assumes: TX_READY comes from serialiser logic on SYS_CLK
// Notes: 41-byte packet, content frozen at packet start
`timescale 1ns/1ps
`include "fmp_map.svh"

// Summary of operation
// RL1 - Send one report every 1000 ms unprompted
// RL2 - Start with EE, DD, layout version
// RL3 - Six UTC bytes, year from 1900, >=70
// RL4 - Four byte microseconds, at most 999999
// RL5 - State byte bits 7:5 carry operating state
// RL6 - Bits 4:3 zero, bits 2:0 rolling counter
// RL7 - Counter starts zero, steps per update, wraps
// RL8 - Queue byte bits 7:4 hold fault count
// RL9 - Bits 3:0 hold one-based queue position
// RL10 - One 16-bit fault code follows
// RL11 - Twenty reserved bytes, CRC over state..reserved
// RL12 - CRC poly 04C11DB7, init all ones
// RL13 - Multi-byte fields go out LSB first
module fmp_framer #(
  parameter int PERIOD_CYC = (`FMP_CLK_HZ / 1000) * `FMP_PERIOD_MS
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output fmp_pkg::fmp_byte_t TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY
);
  import fmp_pkg::*;

  localparam int CW = $clog2(PERIOD_CYC);
  localparam logic [CW-1:0] TOP = CW'(PERIOD_CYC - 1);

  // Register file
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] date_hi_reg, date_hi_next;
  logic [31:0] date_lo_reg, date_lo_next;
  logic [31:0] usec_reg, usec_next;
  logic [31:0] fault_reg, fault_next;
  logic [31:0] rdata_reg, rdata_next;

  // Framer
  fmp_state_e state_reg, state_next;
  logic [CW-1:0] div_reg, div_next;
  logic tick_reg, tick_next;
  logic pend_reg, pend_next;
  logic [5:0] idx_reg, idx_next;
  logic [2:0] roll_reg, roll_next;
  logic [15:0] pkts_reg, pkts_next;
  fmp_snap_s snap_reg, snap_next;
  fmp_byte_t tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  logic load;
  logic start;
  logic done;

  fmp_crc_if crc_bus ();

  fmp_crc u_crc (
    .clk(SYS_CLK),
    .rst(RST),
    .crc(crc_bus.engine)
  );

  function automatic fmp_byte_t pkt_byte(input logic [5:0] i, input fmp_snap_s s,
                                         input logic [2:0] roll, input logic [31:0] c);
    fmp_byte_t b;
    b = 8'h00;
    if (i == `FMP_IDX_SYNC0) begin
      b = `FMP_SYNC0; // RL2
    end else if (i == `FMP_IDX_SYNC1) begin
      b = `FMP_SYNC1; // RL2
    end else if (i == `FMP_IDX_VER) begin
      b = s.version; // RL2
    end else if (i < `FMP_IDX_USEC) begin
      b = s.date[3'(i - `FMP_IDX_DATE)]; // RL3
    end else if (i < `FMP_IDX_STATE) begin
      b = s.usec[8 * 2'(i - `FMP_IDX_USEC) +: 8]; // RL4 RL13
    end else if (i == `FMP_IDX_STATE) begin
      b = {s.op_state, 2'b00, roll}; // RL5 RL6
    end else if (i == `FMP_IDX_QUEUE) begin
      b = {s.count, s.position}; // RL8 RL9
    end else if (i < `FMP_IDX_RSVD) begin
      b = s.code[8 * 1'(i - `FMP_IDX_CODE) +: 8]; // RL10 RL13
    end else if (i < `FMP_IDX_CRC) begin
      b = 8'h00; // RL11
    end else begin
      b = c[8 * 2'(i - `FMP_IDX_CRC) +: 8]; // RL11 RL13
    end
    return b;
  endfunction : pkt_byte

  // Register port
  always_comb begin
    ctrl_next = ctrl_reg;
    date_hi_next = date_hi_reg;
    date_lo_next = date_lo_reg;
    usec_next = usec_reg;
    fault_next = fault_reg;
    rdata_next = 32'h0000_0000;
    if (WR) begin
      unique case (ADDR)
        `FMP_OFF_CTRL: ctrl_next = WDATA & 32'h0007_ff01;
        `FMP_OFF_DATE_HI: begin
          date_hi_next = WDATA;
          if (WDATA[31:24] < `FMP_YEAR_MIN) begin
            date_hi_next[31:24] = `FMP_YEAR_MIN; // RL3
          end
        end
        `FMP_OFF_DATE_LO: date_lo_next = WDATA & 32'h0000_ffff;
        `FMP_OFF_USEC: begin
          usec_next = (WDATA > `FMP_USEC_MAX) ? `FMP_USEC_MAX : WDATA; // RL4
        end
        `FMP_OFF_FAULT: fault_next = WDATA & 32'h00ff_ffff;
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        `FMP_OFF_CTRL: rdata_next = ctrl_reg;
        `FMP_OFF_DATE_HI: rdata_next = date_hi_reg;
        `FMP_OFF_DATE_LO: rdata_next = date_lo_reg;
        `FMP_OFF_USEC: rdata_next = usec_reg;
        `FMP_OFF_FAULT: rdata_next = fault_reg;
        `FMP_OFF_STATUS: begin
          rdata_next = {pkts_reg, 11'h000, pend_reg, (state_reg != FMP_IDLE), roll_reg};
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= `FMP_RST_CTRL;
      date_hi_reg <= `FMP_RST_DATE_HI;
      date_lo_reg <= `FMP_RST_DATE_LO;
      usec_reg <= `FMP_RST_USEC;
      fault_reg <= `FMP_RST_FAULT;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      date_hi_reg <= date_hi_next;
      date_lo_reg <= date_lo_next;
      usec_reg <= usec_next;
      fault_reg <= fault_next;
      rdata_reg <= rdata_next;
    end
  end

  // Packet engine
  assign start = (state_reg == FMP_IDLE) && pend_reg;
  assign load = (state_reg == FMP_SEND) && (!tx_valid_reg || TX_READY);
  assign done = (state_reg == FMP_DRAIN) && TX_READY;
  assign crc_bus.init = start;
  assign crc_bus.en = load && (idx_reg >= `FMP_IDX_STATE) && (idx_reg < `FMP_IDX_CRC); // RL11
  assign crc_bus.data = tx_data_next;

  always_comb begin
    div_next = (div_reg == TOP) ? '0 : CW'(div_reg + 1'b1); // RL1
    tick_next = (div_reg == TOP); // RL1
    pend_next = pend_reg;
    if (start) begin
      pend_next = 1'b0;
    end
    if (tick_reg && ctrl_reg[`FMP_CTRL_EN]) begin
      pend_next = 1'b1; // RL1
    end
    state_next = state_reg;
    idx_next = idx_reg;
    roll_next = roll_reg;
    pkts_next = pkts_reg;
    snap_next = snap_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    unique case (state_reg)
      FMP_IDLE: begin
        if (start) begin
          snap_next.version = ctrl_reg[`FMP_CTRL_VER];
          snap_next.date = {date_lo_reg[7:0], date_lo_reg[15:8], date_hi_reg[7:0],
                            date_hi_reg[15:8], date_hi_reg[23:16], date_hi_reg[31:24]};
          snap_next.usec = usec_reg;
          snap_next.op_state = ctrl_reg[`FMP_CTRL_STATE];
          snap_next.count = fault_reg[`FMP_FAULT_CNT];
          snap_next.position = fault_reg[`FMP_FAULT_POS];
          snap_next.code = fault_reg[`FMP_FAULT_CODE];
          idx_next = `FMP_IDX_SYNC0;
          state_next = FMP_SEND;
        end
      end
      FMP_SEND: begin
        if (load) begin
          tx_data_next = pkt_byte(idx_reg, snap_reg, roll_reg, crc_bus.value);
          tx_valid_next = 1'b1;
          if (idx_reg == `FMP_IDX_LAST) begin
            state_next = FMP_DRAIN;
          end else begin
            idx_next = idx_reg + 6'd1;
          end
        end
      end
      FMP_DRAIN: begin
        if (done) begin
          tx_valid_next = 1'b0;
          roll_next = roll_reg + 3'd1; // RL7
          pkts_next = pkts_reg + 16'd1;
          state_next = FMP_IDLE;
        end
      end
      default: state_next = FMP_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= FMP_IDLE;
      div_reg <= '0;
      tick_reg <= 1'b0;
      pend_reg <= 1'b0;
      idx_reg <= 6'd0;
      roll_reg <= 3'd0; // RL7
      pkts_reg <= 16'h0000;
      snap_reg <= '0;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      tick_reg <= tick_next;
      pend_reg <= pend_next;
      idx_reg <= idx_next;
      roll_reg <= roll_next;
      pkts_reg <= pkts_next;
      snap_reg <= snap_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
    end
  end

  assign RDATA = rdata_reg;
  assign TX_DATA = tx_data_reg;
  assign TX_VALID = tx_valid_reg;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  tick_start_a: assert property ( // RL1
    tick_reg && ctrl_reg[`FMP_CTRL_EN] |=> pend_reg)
    else $error("tick did not request a packet");
  sync_first_a: assert property ( // RL2
    load && idx_reg == `FMP_IDX_SYNC0 |=> TX_DATA == `FMP_SYNC0 && TX_VALID)
    else $error("first byte not sync 0");
  sync_second_a: assert property ( // RL2
    load && idx_reg == `FMP_IDX_SYNC1 |=> TX_DATA == `FMP_SYNC1)
    else $error("second byte not sync 1");
  year_floor_a: assert property ( // RL3
    date_hi_reg[31:24] >= `FMP_YEAR_MIN)
    else $error("year below floor");
  usec_range_a: assert property ( // RL4
    usec_reg <= `FMP_USEC_MAX)
    else $error("microseconds out of range");
  state_byte_a: assert property ( // RL5
    load && idx_reg == `FMP_IDX_STATE
    |=> TX_DATA == {snap_reg.op_state, 2'b00, roll_reg})
    else $error("state byte wrong");
  roll_step_a: assert property ( // RL7
    done |=> roll_reg == $past(roll_reg) + 3'd1 ##1 roll_reg == $past(roll_reg))
    else $error("rolling counter did not step once");
  queue_byte_a: assert property ( // RL8
    load && idx_reg == `FMP_IDX_QUEUE |=> TX_DATA == {snap_reg.count, snap_reg.position})
    else $error("queue byte wrong");
  code_low_a: assert property ( // RL10
    load && idx_reg == `FMP_IDX_CODE |=> TX_DATA == snap_reg.code[7:0])
    else $error("fault code low byte wrong");
  crc_init_a: assert property ( // RL12
    start |=> crc_bus.value == `FMP_CRC_INIT)
    else $error("checksum not seeded");
  crc_low_a: assert property ( // RL11
    load && idx_reg == `FMP_IDX_CRC |=> TX_DATA == crc_bus.value[7:0])
    else $error("checksum low byte wrong");

  pkt_done_c: cover property (done);
  stall_c: cover property (TX_VALID && !TX_READY ##1 TX_VALID && TX_READY);
  roll_wrap_c: cover property (done && roll_reg == 3'd7);
endmodule : fmp_framer

// *** verif/fmp_host.sv ***
// Purpose: Host side sink for fault report packets
// Assumes: Same clock as the framer, 41 byte packets
// Notes: slow=1 stalls every other cycle; checks trailer
`timescale 1ns/1ps
module fmp_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready,
  output logic done,
  output logic crc_ok
);
  logic [7:0] pkt [0:40];
  int cnt;
  logic phase;

  function automatic logic [31:0] crc_calc();
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 13; i < 37; i++) begin
      c = c ^ {pkt[i], 24'h0};
      for (int b = 0; b < 8; b++) begin
        c = c[31] ? ((c << 1) ^ 32'h04c1_1db7) : (c << 1);
      end
    end
    return c;
  endfunction : crc_calc

  assign tx_ready = !slow || phase;

  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      cnt = 0;
      phase <= 1'b0;
      crc_ok <= 1'b0;
    end else begin
      phase <= !phase;
      if (tx_valid && tx_ready) begin
        pkt[cnt] = tx_data;
        cnt = cnt + 1;
        if (cnt == 41) begin
          crc_ok <= (crc_calc() === {pkt[40], pkt[39], pkt[38], pkt[37]});
          done <= 1'b1;
          cnt = 0;
        end
      end
    end
  end
endmodule : fmp_host

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the fault report framer
// Assumes: Period shortened to 200 cycles
// Notes: Packets compared byte by byte against field settings
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic slow;
  logic done;
  logic crc_ok;
  logic [31:0] v;
  logic [7:0] date [0:5];
  logic [7:0] ver;
  logic [2:0] st;
  logic [31:0] usec;
  logic [15:0] code;
  logic [3:0] qcnt;
  logic [3:0] qpos;
  int err_total = 0;
  int num_checks = 0;
  int cyc_now = 0;
  int t_done;
  int t_prev;
  int seen;
  logic vld_q = 1'b0;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc_now <= cyc_now + 1;

  // First byte of a packet shows a fixed delay after the tick, whatever the sink's pace
  always @(posedge sys_clk) begin
    vld_q <= tx_valid;
    if (tx_valid && !vld_q) begin
      t_prev <= t_done;
      t_done <= cyc_now;
    end
  end

  fmp_framer #(.PERIOD_CYC(200)) fmp_framer_inst (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready));
  fmp_host fmp_host_inst (.clk(sys_clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .slow(slow), .tx_ready(tx_ready), .done(done), .crc_ok(crc_ok));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
  endtask : rd_reg

  task automatic wait_pkt();
    int n;
    n = 0;
    while (1) begin
      @(posedge sys_clk);
      n++;
      if (done === 1'b1) break;
      if (n > 1000) begin
        check("packet timeout", 0, 1);
        end_of_test();
      end
    end
  endtask : wait_pkt

  task automatic check_pkt(logic [2:0] roll);
    logic [7:0] e [0:36];
    e = '{default: 8'h00};
    e[0] = 8'hee;
    e[1] = 8'hdd;
    e[2] = ver;
    for (int i = 0; i < 6; i++) e[3 + i] = date[i];
    for (int i = 0; i < 4; i++) e[9 + i] = usec[8 * i +: 8];
    e[13] = {st, 2'b00, roll};
    e[14] = {qcnt, qpos};
    e[15] = code[7:0];
    e[16] = code[15:8];
    for (int i = 0; i < 37; i++) begin
      check("packet byte", {24'h0, fmp_host_inst.pkt[i]}, {24'h0, e[i]});
    end
    check("trailer", {31'h0, crc_ok}, 32'h1);
  endtask : check_pkt

  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wr_reg(8'h00, 32'h0);
    rd_reg(8'h04, v);
    check("date hi reset", v, 32'h4601_0100);
    rd_reg(8'h0c, v);
    check("usec reset", v, 32'h0);
    rd_reg(8'h14, v);
    check("roll reset", {29'h0, v[2:0]}, 32'h0);
    $display("test reset done");
    wr_reg(8'h0c, 32'd1000000);
    rd_reg(8'h0c, v);
    check("usec clamp", v, 32'd999999);
    wr_reg(8'h04, 32'h4501_0100);
    rd_reg(8'h04, v);
    check("year clamp", v, 32'h4601_0100);
    wr_reg(8'h18, 32'hffff_ffff);
    rd_reg(8'h18, v);
    check("unmapped read", v, 32'h0);
    $display("test limits done");
    for (int k = 0; k < 10; k++) begin
      st = 3'(k % 4);
      ver = 8'(8'h10 + k);
      date = '{8'(70 + k), 8'(k + 1), 8'(k + 5), 8'(k + 10), 8'(k + 20), 8'(59 - k)};
      usec = (k == 0) ? 32'd999999 : 32'h0001_2345 + 32'(k);
      code = 16'ha5c3 ^ 16'(k);
      qcnt = 4'(15 - k);
      qpos = 4'(k + 1);
      slow <= k[0];
      wr_reg(8'h04, {date[0], date[1], date[2], date[3]});
      wr_reg(8'h08, {16'h0, date[4], date[5]});
      wr_reg(8'h0c, usec);
      wr_reg(8'h10, {8'h0, qcnt, qpos, code});
      wr_reg(8'h00, {13'h0, st, ver, 8'h01});
      wait_pkt();
      check_pkt(3'(k));
      if (k > 0) check("packet interval", t_done - t_prev, 200);
    end
    rd_reg(8'h14, v);
    check("roll after wrap", {29'h0, v[2:0]}, 32'h2);
    check("packets sent", {16'h0, v[31:16]}, 32'd10);
    $display("test packets done");
    wr_reg(8'h00, 32'h0);
    seen = 0;
    repeat (500) begin
      @(posedge sys_clk);
      if (done === 1'b1) seen++;
    end
    check("disabled packets", seen, 0);
    $display("test disable done");
    end_of_test();
  end
endmodule : testbench
